// File: core/flash_regs_pkg.sv
package flash_regs_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 50;
  localparam int STATUS_WRITE_US = 10;
  localparam int PROGRAM_US = 400;
  localparam int ERASE_US = 1000;
  localparam int SOFT_RESET_US = 30;
  localparam int STATUS_WRITE_CYCLES = STATUS_WRITE_US * CLK_MHZ;
  localparam int PROGRAM_CYCLES = PROGRAM_US * CLK_MHZ;
  localparam int ERASE_CYCLES = ERASE_US * CLK_MHZ;
  localparam int SOFT_RESET_CYCLES = SOFT_RESET_US * CLK_MHZ;
  localparam int TIMER_W = 24;

  // ---------------------------------------------------------------
  // Instruction codes
  // ---------------------------------------------------------------
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_READ_SR1 = 8'h05;
  localparam logic [7:0] OP_READ_SR2 = 8'h35;
  localparam logic [7:0] OP_READ_SR3 = 8'h15;
  localparam logic [7:0] OP_WRITE_SR1 = 8'h01;
  localparam logic [7:0] OP_WRITE_SR2 = 8'h31;
  localparam logic [7:0] OP_WRITE_SR3 = 8'h11;
  localparam logic [7:0] OP_PAGE_PROG = 8'h02;
  localparam logic [7:0] OP_QUAD_PROG = 8'h32;
  localparam logic [7:0] OP_ERASE_4K = 8'h20;
  localparam logic [7:0] OP_ERASE_32K = 8'h52;
  localparam logic [7:0] OP_ERASE_64K = 8'hd8;
  localparam logic [7:0] OP_CHIP_ERASE_A = 8'hc7;
  localparam logic [7:0] OP_CHIP_ERASE_B = 8'h60;
  localparam logic [7:0] OP_SECREG_ERASE = 8'h44;
  localparam logic [7:0] OP_SECREG_PROG = 8'h42;
  localparam logic [7:0] OP_SUSPEND = 8'h75;
  localparam logic [7:0] OP_RESUME = 8'h7a;
  localparam logic [7:0] OP_QPI_ENTER = 8'h38;
  localparam logic [7:0] OP_QPI_EXIT = 8'hff;
  localparam logic [7:0] OP_RESET_ENABLE = 8'h66;
  localparam logic [7:0] OP_RESET = 8'h99;

  // ---------------------------------------------------------------
  // Bit positions inside each status byte
  // ---------------------------------------------------------------
  localparam int BUSY_POS = 0;
  localparam int WR_EN_POS = 1;
  localparam int PROT_LSB = 2;
  localparam int TOPBOT_POS = 5;
  localparam int GRANULE_POS = 6;
  localparam int LOCK_LOW_POS = 7;
  localparam int LOCK_HIGH_POS = 0;
  localparam int QUAD_POS = 1;
  localparam int OTP_LSB = 3;
  localparam int COMPL_POS = 6;
  localparam int PAUSED_POS = 7;
  localparam int LATENCY_LSB = 0;
  localparam int DRIVE_POS = 5;
  localparam int HOLDRST_POS = 7;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_OPCODE = 3'h1,
    ST_DATA = 3'h3,
    ST_READ = 3'h2,
    ST_SKIP = 3'h6
  } phase_t;

  typedef enum logic [2:0] {
    JOB_NONE = 3'h0,
    JOB_STATUS = 3'h1,
    JOB_PROG = 3'h2,
    JOB_ERASE = 3'h3,
    JOB_RESET = 3'h4
  } job_t;

  typedef struct packed {
    logic complement_protect;
    logic [2:0] otp_lock;
    logic quad_enable;
    logic status_lock_high;
    logic status_lock_low;
    logic granule_select;
    logic top_bottom_select;
    logic [2:0] protect_field;
    logic hold_reset_sel;
    logic drive_strength;
    logic [1:0] latency_code;
  } cfg_t;

  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic [3:0] io;
  } pins_t;

  localparam cfg_t CFG_RESET = '0;
  localparam pins_t PINS_IDLE = '{cs_n: 1'b1, sclk: 1'b0, io: 4'hf};

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [7:0] status_byte(input logic [1:0] sel,
      input cfg_t c, input logic busy, input logic write_enable_latch, input logic paused_op_flag);
    logic [7:0] b;
    b = 8'h00;
    case (sel)
      2'd0: begin
        b[BUSY_POS] = busy;
        b[WR_EN_POS] = write_enable_latch;
        b[PROT_LSB +: 3] = c.protect_field;
        b[TOPBOT_POS] = c.top_bottom_select;
        b[GRANULE_POS] = c.granule_select;
        b[LOCK_LOW_POS] = c.status_lock_low;
      end
      2'd1: begin
        b[LOCK_HIGH_POS] = c.status_lock_high;
        b[QUAD_POS] = c.quad_enable;
        b[OTP_LSB +: 3] = c.otp_lock;
        b[COMPL_POS] = c.complement_protect;
        b[PAUSED_POS] = paused_op_flag;
      end
      default: begin
        b[LATENCY_LSB +: 2] = c.latency_code;
        b[DRIVE_POS] = c.drive_strength;
        b[HOLDRST_POS] = c.hold_reset_sel;
      end
    endcase
    return b;
  endfunction

  function automatic cfg_t apply_write(input logic [1:0] sel,
      input logic [7:0] d, input cfg_t c);
    cfg_t n;
    n = c;
    case (sel)
      2'd0: begin
        n.protect_field = d[PROT_LSB +: 3];
        n.top_bottom_select = d[TOPBOT_POS];
        n.granule_select = d[GRANULE_POS];
        n.status_lock_low = d[LOCK_LOW_POS];
      end
      2'd1: begin
        n.status_lock_high = d[LOCK_HIGH_POS];
        n.quad_enable = d[QUAD_POS];
        n.otp_lock = c.otp_lock | d[OTP_LSB +: 3];
        n.complement_protect = d[COMPL_POS];
      end
      default: begin
        n.latency_code = d[LATENCY_LSB +: 2];
        n.drive_strength = d[DRIVE_POS];
        n.hold_reset_sel = d[HOLDRST_POS];
      end
    endcase
    return n;
  endfunction

  function automatic logic write_allowed(input cfg_t c, input logic write_enable_latch,
      input logic wp_high, input logic quad);
    logic ok;
    case ({c.status_lock_high, c.status_lock_low})
      2'b00: ok = write_enable_latch;
      2'b01: ok = write_enable_latch & (wp_high | quad);
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  function automatic logic [3:0] dummy_clocks(input logic [1:0] code);
    logic [3:0] n;
    case (code)
      2'b01: n = 4'h4;
      2'b10: n = 4'h8;
      2'b11: n = 4'ha;
      default: n = 4'h6;
    endcase
    return n;
  endfunction

endpackage

// File: core/pin_sync.sv
`timescale 1ns/100ps
module pin_sync (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  // Raw pins and filtered levels
  input wire flash_regs_pkg::pins_t pins_i,
  output flash_regs_pkg::pins_t pins_o
);
  import flash_regs_pkg::*;

  pins_t s1_q, s2_q, s3_q, lvl_q, lvl_d;

  // -----------------------------------------------------------------
  // Level follows once second and third stages agree
  // -----------------------------------------------------------------
  always_comb begin
    lvl_d = (s2_q & s3_q) | (lvl_q & (s2_q ^ s3_q));
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      s1_q <= PINS_IDLE;
      s2_q <= PINS_IDLE;
      s3_q <= PINS_IDLE;
      lvl_q <= PINS_IDLE;
    end else if (ce_i) begin
      s1_q <= pins_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= lvl_d;
    end
  end

  assign pins_o = lvl_q;

endmodule // pin_sync

// File: core/flash_status_config_regs.sv
`timescale 1ns/100ps
// Notes on behaviour
// - Status bit 0 shows internal job running
// - While running, only status reads and suspend
// - Job end clears the running flag
// - Write enable sets the latch
// - Latch cleared by disable, program, erase, writes
// - Three protect bits, writable, default zero
// - Top/bottom select, default top
// - Granule select: sectors or blocks, default blocks
// - Complement bit inverts protected region
// - Locks 00: write needs only latch
// - Locks 01: low protect pin blocks writes
// - Locks 10: refused until power cycle
// - Locks 11: writes refused until power cycle, which clears the locks as for 10
// - Protect pin ignored when quad lines used
// - Suspend sets paused flag, resume clears
// - OTP lock bits only set, then locked
// - Quad enable turns pins into data
// - Enter QPI ignored unless quad enabled
// - Drive strength bit: full or reduced
// - Hold or reset pin, only without quad
// - Latency code picks DTR dummy clocks
// - Reserved bits read zero, writes ignored
// - Quad enable defaults to zero
module flash_status_config_regs #(
  parameter int STATUS_WRITE_CYCLES = flash_regs_pkg::STATUS_WRITE_CYCLES,
  parameter int PROGRAM_CYCLES = flash_regs_pkg::PROGRAM_CYCLES,
  parameter int ERASE_CYCLES = flash_regs_pkg::ERASE_CYCLES
) (
  // Clock, reset, enable
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  // Serial pins
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic [3:0] io_i,
  output logic [3:0] io_o,
  output logic [3:0] io_oe_o,
  // Configuration and state towards the array
  output flash_regs_pkg::cfg_t cfg_o,
  output logic busy_o,
  output logic write_enable_latch_o,
  output logic qpi_mode_o,
  output logic hold_active_o,
  output logic [3:0] dummy_clocks_o
);
  import flash_regs_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  pins_t pin, prev_q, prev_d, raw;
  phase_t phase_q, phase_d;
  job_t job_q, job_d;
  cfg_t cfg_q, cfg_d;
  logic [TIMER_W-1:0] timer_q, timer_d;
  logic [3:0] bit_cnt_q, bit_cnt_d;
  logic [2:0] byte_cnt_q, byte_cnt_d;
  logic [2:0] out_cnt_q, out_cnt_d;
  logic [7:0] shreg_q, shreg_d;
  logic [7:0] opcode_q, opcode_d;
  logic [7:0] byte1_q, byte1_d;
  logic [7:0] byte2_q, byte2_d;
  logic [7:0] out_sh_q, out_sh_d;
  logic [1:0] sel_q, sel_d;
  logic wel_q, wel_d;
  logic sus_q, sus_d;
  logic qpi_q, qpi_d;
  logic armed_q, armed_d;
  logic started_q, started_d;
  logic [3:0] io_q, io_d;
  logic [3:0] oe_q, oe_d;
  logic busy_q, busy_d;
  logic hold_q, hold_d;
  logic [3:0] dummy_q, dummy_d;

  assign raw = '{cs_n: cs_n_i, sclk: sclk_i, io: io_i};

  pin_sync u_sync (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .ce_i(ce_i),
    .pins_i(raw),
    .pins_o(pin)
  );

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    logic hold, pin_rst, sclk_r, sclk_f, cs_rise, cs_fall, done;
    logic running, quad, wp_high, lock_hit, wr_ok;
    logic [3:0] step, nbits;
    logic [7:0] nbyte, bytev;
    logic [1:0] idx;
    hold = 1'b0;
    pin_rst = 1'b0;
    sclk_r = 1'b0;
    sclk_f = 1'b0;
    cs_rise = 1'b0;
    cs_fall = 1'b0;
    done = 1'b0;
    running = 1'b0;
    quad = 1'b0;
    wp_high = 1'b0;
    lock_hit = 1'b0;
    wr_ok = 1'b0;
    step = 4'h1;
    nbits = 4'h0;
    nbyte = 8'h00;
    bytev = 8'h00;
    idx = 2'd0;
    prev_d = pin;
    phase_d = phase_q;
    job_d = job_q;
    cfg_d = cfg_q;
    timer_d = timer_q;
    bit_cnt_d = bit_cnt_q;
    byte_cnt_d = byte_cnt_q;
    out_cnt_d = out_cnt_q;
    shreg_d = shreg_q;
    opcode_d = opcode_q;
    byte1_d = byte1_q;
    byte2_d = byte2_q;
    out_sh_d = out_sh_q;
    sel_d = sel_q;
    wel_d = wel_q;
    sus_d = sus_q;
    qpi_d = qpi_q;
    armed_d = armed_q;
    started_d = started_q;
    io_d = io_q;

    // Pin roles
    quad = cfg_q.quad_enable | qpi_q;
    hold = ~quad & ~cfg_q.hold_reset_sel & ~pin.io[3] & ~pin.cs_n;
    pin_rst = ~quad & cfg_q.hold_reset_sel & ~pin.io[3];
    wp_high = pin.io[2];
    sclk_r = pin.sclk & ~prev_q.sclk & ~hold;
    sclk_f = ~pin.sclk & prev_q.sclk & ~hold;
    cs_rise = pin.cs_n & ~prev_q.cs_n;
    cs_fall = ~pin.cs_n & prev_q.cs_n;
    running = (job_q == JOB_STATUS) | (job_q == JOB_PROG) |
              (job_q == JOB_ERASE);
    step = qpi_q ? 4'h4 : 4'h1;
    nbits = bit_cnt_q + step;
    nbyte = qpi_q ? {shreg_q[3:0], pin.io} : {shreg_q[6:0], pin.io[0]};
    done = sclk_r & (nbits == 4'h8);

    // Internal job timer; a paused job keeps its count
    if (job_q != JOB_NONE && !sus_q) begin
      if (timer_q == '0) begin
        job_d = JOB_NONE;
      end else begin
        timer_d = timer_q - 1'b1;
      end
    end

    // Serial framing
    case (phase_q)
      ST_IDLE: begin
        if (cs_fall) begin
          phase_d = ST_OPCODE;
          bit_cnt_d = 4'h0;
          byte_cnt_d = 3'd0;
        end
      end
      ST_OPCODE: begin
        if (sclk_r) begin
          shreg_d = nbyte;
          bit_cnt_d = done ? 4'h0 : nbits;
        end
        if (done) begin
          opcode_d = nbyte;
          byte_cnt_d = 3'd1;
          out_cnt_d = 3'd0;
          if (job_q == JOB_RESET) begin
            phase_d = ST_SKIP;
          end else if (nbyte == OP_READ_SR1) begin
            phase_d = ST_READ;
            sel_d = 2'd0;
          end else if (nbyte == OP_READ_SR2) begin
            phase_d = ST_READ;
            sel_d = 2'd1;
          end else if (nbyte == OP_READ_SR3) begin
            phase_d = ST_READ;
            sel_d = 2'd2;
          end else if (running && !sus_q && nbyte != OP_SUSPEND) begin
            phase_d = ST_SKIP;
          end else begin
            phase_d = ST_DATA;
          end
        end
      end
      ST_DATA: begin
        if (sclk_r) begin
          shreg_d = nbyte;
          bit_cnt_d = done ? 4'h0 : nbits;
        end
        if (done) begin
          if (byte_cnt_q != 3'd7) begin
            byte_cnt_d = byte_cnt_q + 3'd1;
          end
          if (byte_cnt_q == 3'd1) begin
            byte1_d = nbyte;
          end
          if (byte_cnt_q == 3'd2) begin
            byte2_d = nbyte;
          end
        end
      end
      ST_READ: begin
        if (sclk_f) begin
          bytev = (out_cnt_q == 3'd0) ?
            status_byte(sel_q, cfg_q, running & ~sus_q, wel_q, sus_q) :
            out_sh_q;
          started_d = 1'b1;
          if (qpi_q) begin
            io_d = bytev[7:4];
            out_sh_d = {bytev[3:0], 4'h0};
            out_cnt_d = out_cnt_q + 3'd4;
          end else begin
            io_d = {2'b00, bytev[7], 1'b0};
            out_sh_d = {bytev[6:0], 1'b0};
            out_cnt_d = out_cnt_q + 3'd1;
          end
        end
      end
      default: begin
      end
    endcase

    // Execution at the end of a frame
    idx = byte2_q[5:4];
    lock_hit = (idx != 2'd0) && cfg_q.otp_lock[idx - 2'd1];
    wr_ok = write_allowed(cfg_q, wel_q, wp_high,
                          quad);
    if (cs_rise) begin
      phase_d = ST_IDLE;
      started_d = 1'b0;
      if (phase_q != ST_IDLE) begin
        armed_d = 1'b0;
      end
      if (phase_q == ST_DATA && bit_cnt_q == 4'h0) begin
        case (opcode_q)
          OP_WRITE_ENABLE: begin
            if (byte_cnt_q == 3'd1) begin
              wel_d = 1'b1;
            end
          end
          OP_WRITE_DISABLE: begin
            if (byte_cnt_q == 3'd1) begin
              wel_d = 1'b0;
            end
          end
          OP_WRITE_SR1, OP_WRITE_SR2, OP_WRITE_SR3: begin
            if (wr_ok && (byte_cnt_q == 3'd2 ||
                (byte_cnt_q == 3'd3 && opcode_q == OP_WRITE_SR1))) begin
              if (opcode_q == OP_WRITE_SR1) begin
                cfg_d = apply_write(2'd0, byte1_q,
                                    cfg_q);
                if (byte_cnt_q == 3'd3) begin
                  cfg_d = apply_write(2'd1, byte2_q, cfg_d);
                end
              end else if (opcode_q == OP_WRITE_SR2) begin
                cfg_d = apply_write(2'd1, byte1_q,
                                    cfg_q);
              end else begin
                cfg_d = apply_write(2'd2, byte1_q,
                                    cfg_q);
              end
              wel_d = 1'b0;
              job_d = JOB_STATUS;
              timer_d = TIMER_W'(STATUS_WRITE_CYCLES - 1);
            end
          end
          OP_PAGE_PROG, OP_QUAD_PROG, OP_SECREG_PROG: begin
            if (wel_q && byte_cnt_q >= 3'd5 &&
                !(opcode_q == OP_SECREG_PROG && lock_hit)) begin
              wel_d = 1'b0;
              job_d = JOB_PROG;
              timer_d = TIMER_W'(PROGRAM_CYCLES - 1);
            end
          end
          OP_ERASE_4K, OP_ERASE_32K, OP_ERASE_64K, OP_SECREG_ERASE,
          OP_CHIP_ERASE_A, OP_CHIP_ERASE_B: begin
            if (wel_q && !(opcode_q == OP_SECREG_ERASE && lock_hit) &&
                ((byte_cnt_q == 3'd1 && (opcode_q == OP_CHIP_ERASE_A ||
                  opcode_q == OP_CHIP_ERASE_B)) ||
                 (byte_cnt_q == 3'd4 && opcode_q != OP_CHIP_ERASE_A &&
                  opcode_q != OP_CHIP_ERASE_B))) begin
              wel_d = 1'b0;
              job_d = JOB_ERASE;
              timer_d = TIMER_W'(ERASE_CYCLES - 1);
            end
          end
          OP_SUSPEND: begin
            if ((job_q == JOB_PROG || job_q == JOB_ERASE) && !sus_q) begin
              sus_d = 1'b1;
            end
          end
          OP_RESUME: begin
            sus_d = 1'b0;
          end
          OP_QPI_ENTER: begin
            if (cfg_q.quad_enable) begin
              qpi_d = 1'b1;
            end
          end
          OP_QPI_EXIT: begin
            qpi_d = 1'b0;
          end
          OP_RESET_ENABLE: begin
            armed_d = (byte_cnt_q == 3'd1);
          end
          OP_RESET: begin
            if (armed_q && byte_cnt_q == 3'd1) begin
              wel_d = 1'b0;
              sus_d = 1'b0;
              qpi_d = 1'b0;
              job_d = JOB_RESET;
              timer_d = TIMER_W'(SOFT_RESET_CYCLES - 1);
            end
          end
          default: begin
          end
        endcase
      end
    end

    // Reset pin returns job, latch, suspend, QPI and framing state to power-on values; config is kept
    if (pin_rst) begin
      phase_d = ST_IDLE;
      job_d = JOB_NONE;
      wel_d = 1'b0;
      sus_d = 1'b0;
      qpi_d = 1'b0;
      armed_d = 1'b0;
      started_d = 1'b0;
    end

    // Registered pin and side outputs
    oe_d = (phase_d == ST_READ && started_d && !hold) ?
           (qpi_q ? 4'hf : 4'h2) : 4'h0;
    busy_d = ((job_d == JOB_STATUS) | (job_d == JOB_PROG) |
              (job_d == JOB_ERASE)) & ~sus_d;
    hold_d = hold;
    dummy_d = dummy_clocks(cfg_d.latency_code);
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      prev_q <= PINS_IDLE;
      phase_q <= ST_IDLE;
      job_q <= JOB_NONE;
      cfg_q <= CFG_RESET;
      timer_q <= '0;
      bit_cnt_q <= 4'h0;
      byte_cnt_q <= 3'd0;
      out_cnt_q <= 3'd0;
      shreg_q <= 8'h00;
      opcode_q <= 8'h00;
      byte1_q <= 8'h00;
      byte2_q <= 8'h00;
      out_sh_q <= 8'h00;
      sel_q <= 2'd0;
      wel_q <= 1'b0;
      sus_q <= 1'b0;
      qpi_q <= 1'b0;
      armed_q <= 1'b0;
      started_q <= 1'b0;
      io_q <= 4'h0;
      oe_q <= 4'h0;
      busy_q <= 1'b0;
      hold_q <= 1'b0;
      dummy_q <= 4'h6;
    end else if (ce_i) begin
      prev_q <= prev_d;
      phase_q <= phase_d;
      job_q <= job_d;
      cfg_q <= cfg_d;
      timer_q <= timer_d;
      bit_cnt_q <= bit_cnt_d;
      byte_cnt_q <= byte_cnt_d;
      out_cnt_q <= out_cnt_d;
      shreg_q <= shreg_d;
      opcode_q <= opcode_d;
      byte1_q <= byte1_d;
      byte2_q <= byte2_d;
      out_sh_q <= out_sh_d;
      sel_q <= sel_d;
      wel_q <= wel_d;
      sus_q <= sus_d;
      qpi_q <= qpi_d;
      armed_q <= armed_d;
      started_q <= started_d;
      io_q <= io_d;
      oe_q <= oe_d;
      busy_q <= busy_d;
      hold_q <= hold_d;
      dummy_q <= dummy_d;
    end
  end

  assign io_o = io_q;
  assign io_oe_o = oe_q;
  assign cfg_o = cfg_q;
  assign busy_o = busy_q;
  assign write_enable_latch_o = wel_q;
  assign qpi_mode_o = qpi_q;
  assign hold_active_o = hold_q;
  assign dummy_clocks_o = dummy_q;

endmodule // flash_status_config_regs

// File: verif/flash_regs_chk.sv
`timescale 1ns/100ps
module flash_regs_chk (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // Watched outputs
  input wire flash_regs_pkg::cfg_t cfg_o,
  input wire logic busy_o,
  input wire logic write_enable_latch_o,
  input wire logic qpi_mode_o,
  input wire logic hold_active_o,
  input wire logic [3:0] dummy_clocks_o
);
  import flash_regs_pkg::*;
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (reset_i);
  logic [1:0] locks;
  assign locks = {cfg_o.status_lock_high, cfg_o.status_lock_low};
  sequence s_code_settled;
    $stable(cfg_o.latency_code) [*2];
  endsequence
  sequence s_wel_was_set;
    $past(write_enable_latch_o) || $past(write_enable_latch_o, 2);
  endsequence
  a_dummy_map: assert property (s_code_settled |->
    dummy_clocks_o == (cfg_o.latency_code == 2'h0 ? 4'h6 :
    cfg_o.latency_code == 2'h1 ? 4'h4 :
    cfg_o.latency_code == 2'h2 ? 4'h8 : 4'ha))
    else $error("dummy count wrong");
  a_otp_sticky: assert property (
    ($past(cfg_o.otp_lock) & ~cfg_o.otp_lock) == 3'h0)
    else $error("otp lock cleared");
  a_lock_forever: assert property (
    locks == 2'b11 |=> $stable(cfg_o))
    else $error("config changed under permanent lock");
  a_lock_power: assert property (locks == 2'b10 |=> $stable(cfg_o))
    else $error("config changed under power lock");
  a_write_gate: assert property (!$stable(cfg_o) |->
    s_wel_was_set ##[0:2] !write_enable_latch_o)
    else $error("config change without latch");
  a_busy_blocks_wel: assert property (
    $rose(write_enable_latch_o) |-> !$past(busy_o))
    else $error("latch set while busy");
  a_qpi_needs_quad: assert property (
    $rose(qpi_mode_o) |-> cfg_o.quad_enable)
    else $error("qpi entered without quad enable");
  a_hold_spi_only: assert property (hold_active_o |->
    !cfg_o.quad_enable && !cfg_o.hold_reset_sel && !qpi_mode_o)
    else $error("hold active in wrong mode");
endmodule // flash_regs_chk

// File: verif/spi_host.sv
`timescale 1ns/100ps
module spi_host (
  // Clock
  input wire logic mclk_i,
  // Device pins
  input wire logic io1_i,
  output logic cs_n_o,
  output logic sclk_o,
  output logic io0_o,
  output logic wp_n_o,
  output logic hold_n_o
);
  int gap = 24;
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    io0_o = 1'b0;
    wp_n_o = 1'b1;
    hold_n_o = 1'b1;
  end
  task automatic ticks(input int n);
    repeat (n) @(negedge mclk_i);
  endtask
  // Mode 0 frame, sclk still outside frames
  task automatic frame(input logic [7:0] op, input logic [15:0] dat,
      input int nb, output logic [7:0] rd);
    logic [7:0] b;
    cs_n_o = 1'b0;
    ticks(4);
    for (int k = 0; k <= nb; k++) begin
      b = (k == 0) ? op : (k == 1) ? dat[15:8] : dat[7:0];
      for (int i = 7; i >= 0; i--) begin
        io0_o = b[i];
        ticks(4);
        sclk_o = 1'b1;
        ticks(4);
        rd[i] = io1_i;
        sclk_o = 1'b0;
      end
    end
    ticks(4);
    cs_n_o = 1'b1;
    io0_o = ~io0_o;
    ticks(gap);
  endtask
  task automatic pins(input logic c, input logic w, input logic h);
    cs_n_o = c;
    wp_n_o = w;
    hold_n_o = h;
    ticks(12);
  endtask
endmodule // spi_host

// File: verif/flash_status_config_regs_bench.sv
`timescale 1ns/100ps
module flash_status_config_regs_bench;
  import flash_regs_pkg::*;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic cs_n, sclk, io0, wp_n, hold_n, busy, write_enable_latch, qpi, hold;
  logic [3:0] io_i, io_o, io_oe, dummy;
  cfg_t cfg;
  logic [7:0] seed, rd, d;
  int err_total = 0;
  int comparisons = 0;
  always #10 mclk = ~mclk;
  assign io_i = (io_oe & io_o) | (~io_oe & {hold_n, wp_n, 1'b1, io0});
  flash_status_config_regs #(.STATUS_WRITE_CYCLES(20),
    .PROGRAM_CYCLES(20), .ERASE_CYCLES(1000)) flash_status_config_regs_i (
    .mclk_i(mclk), .reset_i(reset), .ce_i(1'b1), .cs_n_i(cs_n),
    .sclk_i(sclk), .io_i(io_i), .io_o(io_o), .io_oe_o(io_oe),
    .cfg_o(cfg), .busy_o(busy), .write_enable_latch_o(write_enable_latch),
    .qpi_mode_o(qpi), .hold_active_o(hold), .dummy_clocks_o(dummy));
  spi_host spi_host_i (.mclk_i(mclk), .io1_i(io_i[1]), .cs_n_o(cs_n),
    .sclk_o(sclk), .io0_o(io0), .wp_n_o(wp_n), .hold_n_o(hold_n));
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic logic [3:0] exp_dummy(input logic [1:0] c);
    return (c == 2'h1) ? 4'h4 : (c == 2'h2) ? 4'h8 : (c == 2'h3) ? 4'ha : 4'h6;
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic power_cycle;
    reset = 1'b1;
    repeat (10) @(negedge mclk);
    reset = 1'b0;
    repeat (4) @(negedge mclk);
  endtask
  task automatic cmd(input logic [7:0] op);
    spi_host_i.frame(op, 16'h0000, 0, rd);
  endtask
  task automatic rdr(input logic [7:0] op);
    spi_host_i.frame(op, 16'h0000, 1, rd);
  endtask
  task automatic wait_idle;
    for (int i = 0; i < 3000 && busy !== 1'b0; i++) @(negedge mclk);
    chk({7'h0, busy}, 8'h00);
  endtask
  task automatic wr(input logic [7:0] op, input logic [7:0] v);
    cmd(8'h06);
    spi_host_i.frame(op, {v, 8'h00}, 1, rd);
    wait_idle();
  endtask
  task automatic done(input string name);
    $display("test %s finished", name);
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    seed = 8'h4c;
    power_cycle();
    rdr(8'h05);
    chk(rd, 8'h00);
    rdr(8'h35);
    chk(rd, 8'h00);
    rdr(8'h15);
    chk(rd, 8'h00);
    chk({4'h0, dummy}, 8'h06);
    spi_host_i.pins(1'b0, 1'b1, 1'b0);
    chk({7'h0, hold}, 8'h01);
    spi_host_i.pins(1'b1, 1'b1, 1'b1);
    cmd(8'h38);
    chk({7'h0, qpi}, 8'h00);
    done("defaults");
    cmd(8'h06);
    rdr(8'h05);
    chk(rd, 8'h02);
    cmd(8'h04);
    spi_host_i.frame(8'h01, 16'h1c00, 1, rd);
    rdr(8'h05);
    chk(rd, 8'h00);
    done("latch");
    wr(8'h11, 8'h80);
    cmd(8'h06);
    chk({7'h0, write_enable_latch}, 8'h01);
    spi_host_i.pins(1'b1, 1'b1, 1'b0);
    chk({7'h0, write_enable_latch}, 8'h00);
    spi_host_i.pins(1'b1, 1'b1, 1'b1);
    rdr(8'h15);
    chk(rd, 8'h80);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      d = (seed & 8'ha0) | {6'h0, i[1:0]};
      wr(8'h11, d);
      rdr(8'h15);
      chk(rd, d);
      chk({4'h0, dummy}, {4'h0, exp_dummy(d[1:0])});
      seed = lfsr(seed);
      wr(8'h01, seed & 8'h7c);
      rdr(8'h05);
      chk(rd, seed & 8'h7c);
      chk({1'b0, cfg[8:4], 2'h0}, seed & 8'h7c);
    end
    wr(8'h31, 8'h48);
    rdr(8'h35);
    chk(rd, 8'h48);
    wr(8'h31, 8'h00);
    rdr(8'h35);
    chk(rd, 8'h08);
    done("config");
    wr(8'h01, 8'h00);
    cmd(8'h06);
    cmd(8'hc7);
    chk({6'h0, busy, write_enable_latch}, 8'h02);
    cmd(8'h06);
    cmd(8'h75);
    rdr(8'h35);
    chk(rd, 8'h88);
    rdr(8'h05);
    chk(rd, 8'h00);
    cmd(8'h7a);
    chk({7'h0, busy}, 8'h01);
    wait_idle();
    rdr(8'h35);
    chk(rd, 8'h08);
    done("suspend");
    wr(8'h01, 8'h80);
    spi_host_i.pins(1'b1, 1'b0, 1'b1);
    wr(8'h01, 8'h84);
    rdr(8'h05);
    chk(rd, 8'h82);
    spi_host_i.pins(1'b1, 1'b1, 1'b1);
    wr(8'h01, 8'h84);
    rdr(8'h05);
    chk(rd, 8'h84);
    wr(8'h01, 8'h00);
    wr(8'h31, 8'h09);
    wr(8'h01, 8'h10);
    rdr(8'h05);
    chk(rd, 8'h02);
    power_cycle();
    rdr(8'h35);
    chk(rd, 8'h00);
    wr(8'h01, 8'h80);
    wr(8'h31, 8'h01);
    wr(8'h01, 8'h00);
    rdr(8'h05);
    chk(rd, 8'h82);
    done("locks");
    power_cycle();
    wr(8'h31, 8'h02);
    wr(8'h01, 8'h80);
    spi_host_i.pins(1'b1, 1'b0, 1'b1);
    wr(8'h01, 8'h88);
    rdr(8'h05);
    chk(rd, 8'h88);
    spi_host_i.pins(1'b0, 1'b1, 1'b0);
    chk({7'h0, hold}, 8'h00);
    spi_host_i.pins(1'b1, 1'b1, 1'b1);
    cmd(8'h38);
    chk({7'h0, qpi}, 8'h01);
    done("quad");
    close_out();
  end
  initial begin
    repeat (60000) @(posedge mclk);
    err_total++;
    close_out();
  end
endmodule // flash_status_config_regs_bench
bind flash_status_config_regs flash_regs_chk flash_regs_chk_i (
  .mclk_i(mclk_i), .reset_i(reset_i), .cfg_o(cfg_o), .busy_o(busy_o),
  .write_enable_latch_o(write_enable_latch_o), .qpi_mode_o(qpi_mode_o),
  .hold_active_o(hold_active_o), .dummy_clocks_o(dummy_clocks_o));
